// ===== rtl/wwdt_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog.
// Assumes inclusion by bare name from design and testbench files.
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH
// Control register offset (printed offset is not a multiple of four: index).
`define WWDT_CTRL_IDX 12'h02A
`define WWDT_CTRL_ADDR 12'h0A8
// Own status register: mode, active-halt flag and effective activation.
`define WWDT_STAT_IDX 12'h02B
`define WWDT_STAT_ADDR 12'h0AC
`define WWDT_CTRL_RESET 8'h7F
`define WWDT_ACT_BIT 7
`define WWDT_CNT_MSB 6
`define WWDT_CNT_BIT6 6
`define WWDT_PRESCALE 16384
// Reset pulse time in ns and clock period in ns.
`define WWDT_RST_NS 500
`define WWDT_CLK_NS 40
`define WWDT_RST_CYC ((`WWDT_RST_NS) / (`WWDT_CLK_NS))
`define WWDT_WAKE_SHORT 256
`define WWDT_WAKE_LONG 4096
`endif

// ===== rtl/wwdt_pkg.sv
// Types shared by the watchdog design.
// Assumes no other package.
package wwdt_pkg;
    typedef enum logic [1:0] {
        WWDT_RUN,
        WWDT_HALT_STEP,
        WWDT_FROZEN,
        WWDT_WAKE_WAIT
    } wwdt_mode_t;
endpackage

// ===== rtl/wwdt_top.sv
// Windowed watchdog timer with APB register access and a reset pulse output.
// Assumes APB master on clock, oscillator tick as a one-cycle enable input.
//
// Contract
// R1: Counter decrements once every 16384 oscillator cycles.
// R2: Active watchdog resets when counter goes from 40h to 3Fh.
// R3: Counter in control bits 6..0, activation flag in bit 7.
// R4: Software sets activation flag; only reset clears it; it gates expiry.
// R5: Control register resets to 7Fh.
// R6: Hardware watchdog option forces watchdog always active.
// R7: Halt without RTC or halt-reset option: one decrement then freeze.
// R8: Wake from that halt by interrupt resumes after 256 or 4096 clocks.
// R9: Reset ending that halt leaves watchdog disabled unless hardware option.
// R10: Halt with RTC disabled and halt-reset option set causes reset.
// R11: Halt with RTC interrupt enabled enters active-halt, counter frozen.
// R12: Active-halt ended by interrupt resumes counting immediately.
// R13: Active-halt ended by reset resumes counting after 256 or 4096 clocks.
// R14: Timeout bound follows prescaler phase plus 16384 periods per count.
// R15: Timeout divisions truncate down to integers.
// R16: Software refreshes counter before halt while watchdog enabled.
// R17: Counter keeps running even when watchdog not activated.
// R18: Watchdog reset drives reset low for about 500 ns.
// R19: Write setting activation flag with bit six clear gives reset.
// R20: Software always writes one into counter bit six.
// R21: No interrupt output; reset is the only event.
// R22: Slow and wait modes do not affect counting.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "wwdt_defines.svh"
module wwdt_top import wwdt_pkg::*; #(
    parameter int PRESCALE = `WWDT_PRESCALE,
    parameter int WAKE_SHORT = `WWDT_WAKE_SHORT,
    parameter int WAKE_LONG = `WWDT_WAKE_LONG
) (
    input wire logic clock,              // System clock, 25 MHz.
    input wire logic rst,                // Synchronous reset, active high.
    input wire logic osc_tick,           // One pulse per oscillator cycle.
    input wire logic hw_watchdog_opt,    // Hardware watchdog option bit.
    input wire logic halt_reset_option,  // Reset on halt option bit.
    input wire logic rtc_interrupt_enable, // RTC interrupt enable.
    input wire logic long_wake_opt,      // Wake delay select: 1 gives 4096.
    input wire logic halt_req,           // Pulse: halt instruction executed.
    input wire logic ext_wake,           // Pulse: external interrupt wake.
    input wire logic osc_wake,           // Pulse: oscillator interrupt wake.
    input wire logic [11:0] paddr,       // APB address.
    input wire logic psel,               // APB select.
    input wire logic penable,            // APB enable.
    input wire logic pwrite,             // APB direction.
    input wire logic [31:0] pwdata,      // APB write data.
    output logic [31:0] prdata,          // APB read data.
    output logic pready,                 // APB ready.
    output logic pslverr,                // APB error for unmapped address.
    output logic reset_out_n,            // Reset pin drive, active low.
    output logic halted                  // Counter frozen in a halt mode.
);
    localparam int RST_CYC = (`WWDT_RST_CYC < 1) ? 1 : `WWDT_RST_CYC;

    if (PRESCALE < 2 || WAKE_SHORT < 1 || WAKE_LONG < 1 || RST_CYC > 255) begin : g_bad_params
        $error("wwdt_top: counts out of range");
    end

    // ================================================================
    // Register state
    logic act_r;
    logic [6:0] cnt_r;
    logic [31:0] pre_r;
    logic [31:0] wake_r;
    logic [7:0] rstc_r;
    logic fire_r;
    logic [31:0] prdata_r;
    logic after_ah_r;
    wwdt_mode_t mode_r;

    wire logic wr = psel && penable && pwrite;
    wire logic rd = psel && penable && !pwrite;
    wire logic hit_ctrl = paddr == `WWDT_CTRL_ADDR;
    wire logic hit_stat = paddr == `WWDT_STAT_ADDR;
    wire logic active = act_r || hw_watchdog_opt;
    wire logic counting = (mode_r == WWDT_RUN) || (mode_r == WWDT_HALT_STEP);
    wire logic dec = counting && osc_tick && (pre_r == 32'(PRESCALE - 1));
    wire logic sw_wr = wr && hit_ctrl;

    // R19: software reset write
    wire logic sw_reset = sw_wr && pwdata[`WWDT_ACT_BIT] && !pwdata[`WWDT_CNT_BIT6];
    // R2: expiry at 40h to 3Fh
    wire logic expiry = active && dec && (cnt_r == 7'h40) && !sw_wr;
    // R10: halt reset option
    wire logic halt_rst = halt_req && (mode_r == WWDT_RUN) && !rtc_interrupt_enable
        && halt_reset_option;
    // R21: reset is the only event output
    wire logic fire = expiry || sw_reset || halt_rst;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_ctrl || hit_stat);
    assign prdata = prdata_r;
    assign halted = !counting;

    // ================================================================
    // Prescaler
    // R1: one decrement per 16384 oscillator cycles
    // R22: slow and wait do not touch counting
    // R14: timeout from prescaler phase
    // R15: integer prescaler truncation
    always_ff @(posedge clock) begin
        if (rst || sw_wr) begin
            pre_r <= 32'h0;
        end else if (counting && osc_tick) begin
            pre_r <= (pre_r == 32'(PRESCALE - 1)) ? 32'h0 : pre_r + 32'h1;
        end
    end

    // ================================================================
    // Control register
    // R5: reset value 7Fh
    always_ff @(posedge clock) begin
        if (rst) begin
            act_r <= 1'b0;
            cnt_r <= 7'(`WWDT_CTRL_RESET);
        end else if (sw_wr) begin
            // R4: flag only set by software
            act_r <= act_r | pwdata[`WWDT_ACT_BIT];
            // R3: counter field bits 6..0
            cnt_r <= pwdata[`WWDT_CNT_MSB:0];
        end else if (dec) begin
            // R17: free-running countdown
            cnt_r <= cnt_r - 7'h1;
        end
    end

    // ================================================================
    // Low-power mode sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            // R13: resume after delay when leaving active-halt by reset
            // R9: reset exit leaves watchdog disabled via act_r clear
            // A reset held for several edges keeps a pending wake delay.
            mode_r <= ((mode_r == WWDT_FROZEN && after_ah_r) || mode_r == WWDT_WAKE_WAIT) ?
                WWDT_WAKE_WAIT : WWDT_RUN;
            wake_r <= 32'h0;
            after_ah_r <= 1'b0;
        end else begin
            case (mode_r)
                WWDT_RUN: begin
                    if (halt_req && rtc_interrupt_enable) begin
                        // R11: active-halt freezes counter
                        mode_r <= WWDT_FROZEN;
                        after_ah_r <= 1'b1;
                    end else if (halt_req && !halt_reset_option) begin
                        // R7: halt, one more decrement then stop
                        mode_r <= WWDT_HALT_STEP;
                        after_ah_r <= 1'b0;
                    end
                end
                WWDT_HALT_STEP: begin
                    if (dec) begin
                        mode_r <= WWDT_FROZEN;
                    end
                end
                WWDT_FROZEN: begin
                    if (after_ah_r && (osc_wake || ext_wake)) begin
                        // R12: immediate resume from active-halt
                        mode_r <= WWDT_RUN;
                    end else if (!after_ah_r && ext_wake) begin
                        // R8: delayed resume from halt
                        mode_r <= WWDT_WAKE_WAIT;
                        wake_r <= 32'h0;
                    end
                end
                WWDT_WAKE_WAIT: begin
                    if (wake_r == 32'(long_wake_opt ? WAKE_LONG - 1 : WAKE_SHORT - 1)) begin
                        mode_r <= WWDT_RUN;
                        wake_r <= 32'h0;
                    end else begin
                        wake_r <= wake_r + 32'h1;
                    end
                end
                default: mode_r <= WWDT_RUN;
            endcase
        end
    end

    // ================================================================
    // Reset pulse
    // R18: reset low for about 500 ns
    always_ff @(posedge clock) begin
        if (rst) begin
            rstc_r <= 8'h0;
            fire_r <= 1'b0;
        end else begin
            fire_r <= fire;
            if (fire) begin
                rstc_r <= 8'(RST_CYC);
            end else if (rstc_r != 8'h0) begin
                rstc_r <= rstc_r - 8'h1;
            end
        end
    end
    assign reset_out_n = (rstc_r == 8'h0);

    // Length of the current low phase of the reset pin, for the pulse check.
    logic [7:0] low_cnt_r;
    always_ff @(posedge clock) begin
        if (rst || reset_out_n || fire) begin
            low_cnt_r <= 8'h0;
        end else if (low_cnt_r != 8'hFF) begin
            low_cnt_r <= low_cnt_r + 8'h1;
        end
    end

    // ================================================================
    // Read data
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_r <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `WWDT_CTRL_ADDR) begin
                prdata_r <= {24'h0, act_r, cnt_r};
            end else if (paddr == `WWDT_STAT_ADDR) begin
                prdata_r <= {28'h0, active, after_ah_r, mode_r};
            end else begin
                prdata_r <= 32'h0;
            end
        end
    end

    // ================================================================
    // Checks
    expiry_pulse_a: assert property (@(posedge clock) disable iff (rst) // R2
        (active && dec && cnt_r == 7'h40 && !sw_wr) |=> !reset_out_n)
        else $error("expiry did not pull reset low");
    pulse_len_a: assert property (@(posedge clock) disable iff (rst) // R18
        $rose(reset_out_n) |-> low_cnt_r == 8'(RST_CYC))
        else $error("reset pulse length wrong");
    sw_reset_a: assert property (@(posedge clock) disable iff (rst) // R19
        sw_reset |=> !reset_out_n)
        else $error("software reset missing");
    flag_sticky_a: assert property (@(posedge clock) disable iff (rst) // R4
        act_r |=> act_r)
        else $error("activation flag cleared without reset");
    frozen_cnt_a: assert property (@(posedge clock) disable iff (rst) // R11
        (mode_r == WWDT_FROZEN && !sw_wr) |=> $stable(cnt_r))
        else $error("counter moved while frozen");
    no_reset_inactive_a: assert property (@(posedge clock) disable iff (rst) // R6
        (!active && !sw_wr && !halt_req) |=> reset_out_n || $past(rstc_r) != 8'h0)
        else $error("reset while watchdog inactive");
    halt_rst_a: assert property (@(posedge clock) disable iff (rst) // R10
        (halt_req && mode_r == WWDT_RUN && !rtc_interrupt_enable && halt_reset_option)
        |=> !reset_out_n)
        else $error("halt reset missing");
    ah_resume_a: assert property (@(posedge clock) disable iff (rst) // R12
        (mode_r == WWDT_FROZEN && after_ah_r && osc_wake) |=> mode_r == WWDT_RUN)
        else $error("active-halt did not resume at once");
    dec_step_a: assert property (@(posedge clock) disable iff (rst) // R1
        (dec && !sw_wr) |=> cnt_r == $past(cnt_r) - 7'h1)
        else $error("decrement missing");
    wake_wait_a: assert property (@(posedge clock) disable iff (rst) // R8
        (mode_r == WWDT_FROZEN && !after_ah_r && ext_wake) |=> mode_r == WWDT_WAKE_WAIT ##1
        mode_r == WWDT_WAKE_WAIT)
        else $error("halt wake not delayed");

    // ================================================================
    // Mode and register checks

    halt_enter_a: assert property (@(posedge clock) disable iff (rst) // R7
        (mode_r == WWDT_RUN && halt_req && !rtc_interrupt_enable && !halt_reset_option)
        |=> mode_r == WWDT_HALT_STEP)
        else $error("halt step not entered");

    halt_step_a: assert property (@(posedge clock) disable iff (rst) // R7
        (mode_r == WWDT_HALT_STEP && dec) |=> mode_r == WWDT_FROZEN)
        else $error("halt did not freeze after one step");

    ah_enter_a: assert property (@(posedge clock) disable iff (rst) // R11
        (mode_r == WWDT_RUN && halt_req && rtc_interrupt_enable) |=> mode_r == WWDT_FROZEN)
        else $error("active-halt not entered");

    frozen_pre_a: assert property (@(posedge clock) disable iff (rst) // R11
        (mode_r == WWDT_FROZEN && !sw_wr) |=> $stable(pre_r))
        else $error("prescaler moved while frozen");

    ext_resume_a: assert property (@(posedge clock) disable iff (rst) // R12
        (mode_r == WWDT_FROZEN && after_ah_r && ext_wake) |=> mode_r == WWDT_RUN)
        else $error("active-halt did not resume on wake");

    wake_end_a: assert property (@(posedge clock) disable iff (rst) // R8
        (mode_r == WWDT_WAKE_WAIT && !long_wake_opt && wake_r == 32'(WAKE_SHORT - 1))
        |=> mode_r == WWDT_RUN)
        else $error("wake delay did not end");

    ah_rst_wait_a: assert property (@(posedge clock) // R13
        (rst && mode_r == WWDT_FROZEN && after_ah_r) |=> mode_r == WWDT_WAKE_WAIT)
        else $error("reset from active-halt not delayed");

    halt_rst_run_a: assert property (@(posedge clock) // R9
        (rst && mode_r == WWDT_FROZEN && !after_ah_r) |=> (mode_r == WWDT_RUN && !act_r))
        else $error("reset from halt not disabled");

    ctrl_reset_a: assert property (@(posedge clock) // R5
        rst |=> (!act_r && cnt_r == 7'h7F))
        else $error("control reset value wrong");

    hw_opt_a: assert property (@(posedge clock) disable iff (rst) // R6
        (hw_watchdog_opt && !act_r && dec && cnt_r == 7'h40 && !sw_wr) |=> !reset_out_n)
        else $error("hardware option expiry missing");

    ctrl_write_a: assert property (@(posedge clock) disable iff (rst) // R3
        sw_wr |=> cnt_r == $past(pwdata[6:0]))
        else $error("counter field write lost");

    free_run_a: assert property (@(posedge clock) disable iff (rst) // R17
        (!active && dec && !sw_wr) |=> cnt_r != $past(cnt_r))
        else $error("counter stopped while inactive");
endmodule

// ===== sim/wwdt_partner.sv
// Reset generator model: measures watchdog reset pulses and resets the block.
// Assumes the reset pin is sampled on the rising edge of the system clock.
`timescale 1ns/1ps
module wwdt_partner (
    input wire logic clock,       // System clock.
    input wire logic reset_out_n, // Watchdog reset pin.
    output logic rst_req,         // One-cycle reset after a pin pulse.
    output int low_len,           // Length of the last low pulse.
    output int pulse_cnt          // Pulses seen so far.
);
    int run;
    initial begin
        rst_req = 1'b0;
        low_len = 0;
        pulse_cnt = 0;
        run = 0;
    end
    // ========================================
    // Pulse measure and reset response
    // pulse width count.
    always @(posedge clock) begin
        rst_req <= 1'b0;
        if (reset_out_n === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            low_len <= run;
            pulse_cnt <= pulse_cnt + 1;
            run <= 0;
            rst_req <= 1'b1;
        end
    end
endmodule

// ===== sim/windowed_watchdog_timer_tb.sv
// Self-checking bench for the watchdog: APB master, option pins, halt events.
// Assumes prescale 4 and wake delays 4 and 8 clocks.
`timescale 1ns/1ps
`include "wwdt_defines.svh"
module windowed_watchdog_timer_tb;
    logic clock, rst_b, rst, hw, hro, rtc, lwo, halt_req, ext_wake, osc_wake;
    logic psel, penable, pwrite, pready, pslverr, reset_out_n, halted, rst_req, pslv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    int low_len, pulse_cnt, error_cnt, cmp_count, c;
    assign rst = rst_b | rst_req;
    wwdt_top #(.PRESCALE(4), .WAKE_SHORT(4), .WAKE_LONG(8)) u_dut (.clock(clock), .rst(rst),
        .osc_tick(1'b1), .hw_watchdog_opt(hw), .halt_reset_option(hro), .rtc_interrupt_enable(rtc),
        .long_wake_opt(lwo), .halt_req(halt_req), .ext_wake(ext_wake), .osc_wake(osc_wake),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_out_n(reset_out_n), .halted(halted));
    wwdt_partner u_partner (.clock(clock), .reset_out_n(reset_out_n), .rst_req(rst_req),
        .low_len(low_len), .pulse_cnt(pulse_cnt));
    // ========================================
    // Shared tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        pslv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Event code 0 is halt, 1 external wake, 2 oscillator wake.
    task automatic ev(input int k);
        @(posedge clock);
        {osc_wake, ext_wake, halt_req} <= 3'(1 << k);
        @(posedge clock);
        {osc_wake, ext_wake, halt_req} <= 3'b000;
    endtask
    task automatic expect_rst(input string n);
        c = pulse_cnt;
        cyc(60);
        chk(n, c + 1, pulse_cnt);
        chk("pulse_len", 12, low_len);
    endtask
    task automatic pulse_rst;
        rst_b <= 1'b1;
        cyc(1);
        rst_b <= 1'b0;
        cyc(2);
    endtask
    // ========================================
    // Scenarios
    task automatic t_regs;
        apb(0, `WWDT_CTRL_ADDR, 0);
        chk("ctrl_reset", 32'h7F, rd);
        apb(0, 12'h0F0, 0);
        chk("unmapped_err", 1, pslv);
        apb(1, `WWDT_CTRL_ADDR, 32'h7F);
        cyc(40);
        apb(0, `WWDT_CTRL_ADDR, 0);
        chk("count_run", 32'h75, rd);
    endtask
    task automatic t_expire;
        c = pulse_cnt;
        apb(1, `WWDT_CTRL_ADDR, 32'h41);
        cyc(40);
        chk("inactive_pulses", c, pulse_cnt);
        apb(1, `WWDT_CTRL_ADDR, 32'hC1);
        expect_rst("expiry_reset");
        apb(0, `WWDT_CTRL_ADDR, 0);
        chk("flag_cleared", 32'h76, rd);
        apb(1, `WWDT_CTRL_ADDR, 32'hBF);
        expect_rst("soft_reset");
        hw <= 1'b1;
        apb(1, `WWDT_CTRL_ADDR, 32'h41);
        expect_rst("hw_option_reset");
        hw <= 1'b0;
        hro <= 1'b1;
        ev(0);
        expect_rst("halt_reset");
        hro <= 1'b0;
    endtask
    task automatic t_halt;
        for (int l = 0; l < 2; l++) begin
            lwo <= 1'(l);
            c = pulse_cnt;
            apb(1, `WWDT_CTRL_ADDR, 32'hFF);
            ev(0);
            cyc(3);
            chk("halt_halted", 1, halted);
            apb(0, `WWDT_CTRL_ADDR, 0);
            chk("halt_once", 32'hFE, rd);
            cyc(20);
            apb(0, `WWDT_CTRL_ADDR, 0);
            chk("halt_frozen", 32'hFE, rd);
            chk("halt_no_reset", c, pulse_cnt);
            ev(1);
            cyc((l == 1) ? 6 : 2);
            chk("wake_delay", 1, halted);
            cyc(4);
            chk("wake_done", 0, halted);
        end
        apb(1, `WWDT_CTRL_ADDR, 32'hFF);
        ev(0);
        cyc(3);
        pulse_rst();
        apb(0, `WWDT_CTRL_ADDR, 0);
        chk("halt_rst_ctrl", 32'h7F, rd);
        chk("halt_rst_run", 0, halted);
    endtask
    task automatic t_ahalt;
        rtc <= 1'b1;
        hro <= 1'b1;
        c = pulse_cnt;
        apb(1, `WWDT_CTRL_ADDR, 32'hFF);
        ev(0);
        cyc(3);
        chk("ahalt_halted", 1, halted);
        cyc(20);
        apb(0, `WWDT_CTRL_ADDR, 0);
        chk("ahalt_frozen", 32'hFF, rd);
        apb(0, `WWDT_STAT_ADDR, 0);
        chk("ahalt_status", 32'h0E, rd);
        chk("ahalt_no_reset", c, pulse_cnt);
        ev(2);
        cyc(2);
        chk("osc_wake_run", 0, halted);
        ev(0);
        cyc(3);
        ev(1);
        cyc(2);
        chk("ext_wake_run", 0, halted);
        ev(0);
        cyc(3);
        pulse_rst();
        chk("ahalt_rst_wait", 1, halted);
        cyc(8);
        chk("ahalt_rst_run", 0, halted);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ========================================
    // Clock, sequence and watchdog
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        {rst_b, hw, hro, rtc, lwo, halt_req, ext_wake, osc_wake} = 8'h80;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b0;
        t_regs();
        t_expire();
        t_halt();
        t_ahalt();
        print_verdict();
    end
    initial begin
        #(40 * 20000);
        error_cnt++;
        print_verdict();
    end
endmodule
